// [src/cblf_top.sv]
// circular buffer scheduler, pointers, test generator and raw data framer
//
// Register access over Avalon-MM is this design's own decision.
`include "cblf_map.svh"

module cblf_top #(
  parameter int MS_CYCLES = `CBLF_MS_NS / `CBLF_CLK_NS
) (
  // clock and reset
  input  wire logic         clk_sys,
  input  wire logic         reset,
  // avalon-mm register slave
  input  wire logic [5:0]   avs_address,
  input  wire logic         avs_read,
  input  wire logic         avs_write,
  input  wire logic [31:0]  avs_writedata,
  input  wire logic [3:0]   avs_byteenable,
  output logic      [31:0]  avs_readdata,
  output logic              avs_waitrequest,
  // acquisition sources
  input  wire logic         srcBeat,
  input  wire logic         srcSample,
  // memory write command
  output logic              memWrReq,
  output logic      [28:0]  memWrAddr,
  output logic      [8:0]   memWrBeats,
  input  wire logic         memWrDone,
  // data source select and generated word strobe
  output logic              genSelect,
  output logic              genBeat,
  // framer output
  output logic              frameSend,
  output logic      [16:0]  frameLen,
  input  wire logic         frameReady,
  // interrupt
  output logic              irq
);

  // merge byte lanes of a write into an old register value
  function automatic logic [31:0] mergeBe(input logic [31:0] oldV, input logic [31:0] newV,
                                          input logic [3:0] be);
    logic [31:0] r;
    r = oldV;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = newV[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // smaller of two beat counts
  function automatic logic [9:0] minBeats(input logic [9:0] a, input logic [9:0] b);
    return (a < b) ? a : b;
  endfunction

  // registers
  logic [15:0]              latency_ff;
  cblf_pkg::cblf_ptr_t      rdPtr_ff;
  cblf_pkg::cblf_ptr_t      wrPtr_ff;
  cblf_pkg::cblf_ptr_t      ovwPtr_ff;
  logic [31:0]              genRate_ff;
  logic [15:0]              frameTgt_ff;
  logic [7:0]               burst_ff;
  logic                     frmEn_ff;
  logic [`CBLF_INT_WIDTH-1:0] intStat_ff;
  logic [`CBLF_INT_WIDTH-1:0] intMask_ff;
  logic [31:0]              readData_ff;
  logic                     waitReq_ff;
  logic                     irq_ff;

  // bus decode: answer comes one cycle after the request is seen
  logic                     busAck;
  logic                     wrAcc;
  logic [3:0]               regIdx;
  logic [31:0]              regRead;

  assign busAck = !waitReq_ff && (avs_read || avs_write);
  assign wrAcc  = busAck && avs_write;
  assign regIdx = avs_address[5:2];

  // waitrequest high by default, drops for exactly one cycle per access
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      waitReq_ff <= 1'b1;
    end else begin
      waitReq_ff <= !(waitReq_ff && (avs_read || avs_write));
    end
  end

  // read mux; unmapped indices read zero
  always_comb begin
    regRead = 32'h00000000;
    case (regIdx)
      `CBLF_IDX_BURST:    regRead[`CBLF_BURST_MSB:`CBLF_BURST_LSB] = burst_ff;
      `CBLF_IDX_LATENCY:  regRead[`CBLF_LAT_MSB:0] = latency_ff;
      `CBLF_IDX_RDPTR:    regRead[`CBLF_PTR_MSB:`CBLF_PTR_LSB] = rdPtr_ff;
      `CBLF_IDX_WRPTR:    regRead[`CBLF_PTR_MSB:`CBLF_PTR_LSB] = wrPtr_ff;
      `CBLF_IDX_OVWPTR:   regRead[`CBLF_PTR_MSB:`CBLF_PTR_LSB] = ovwPtr_ff;
      `CBLF_IDX_GENRATE:  regRead = genRate_ff;
      `CBLF_IDX_FRAMETGT: regRead[`CBLF_TGT_MSB:0] = frameTgt_ff;
      `CBLF_IDX_INTSTAT:  regRead[`CBLF_INT_WIDTH-1:0] = intStat_ff;
      `CBLF_IDX_INTMASK:  regRead[`CBLF_INT_WIDTH-1:0] = intMask_ff;
      `CBLF_IDX_CTRL:     regRead[`CBLF_CTRL_FRM_EN] = frmEn_ff;
      default:            regRead = 32'h00000000;
    endcase
  end

  // read data captured while waitrequest is high, stands during the ack cycle
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      readData_ff <= 32'h00000000;
    end else if (waitReq_ff && avs_read) begin
      readData_ff <= regRead;
    end
  end

  // software-written configuration
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      latency_ff  <= `CBLF_RST_LATENCY;
      genRate_ff  <= `CBLF_RST_GENRATE;
      frameTgt_ff <= `CBLF_RST_FRAMETGT;
      burst_ff    <= `CBLF_RST_BURST;
      intMask_ff  <= '0;
      frmEn_ff    <= 1'b0;
    end else if (wrAcc) begin
      case (regIdx)
        `CBLF_IDX_LATENCY:  latency_ff  <= 16'(mergeBe({16'h0000, latency_ff}, avs_writedata,
                                                      avs_byteenable));
        `CBLF_IDX_GENRATE:  genRate_ff  <= mergeBe(genRate_ff, avs_writedata, avs_byteenable);
        `CBLF_IDX_FRAMETGT: frameTgt_ff <= 16'(mergeBe({16'h0000, frameTgt_ff}, avs_writedata,
                                                      avs_byteenable));
        `CBLF_IDX_BURST:    burst_ff    <= avs_byteenable[1] ? avs_writedata[11:4]
                                           : (avs_byteenable[0] ? {burst_ff[7:4],
                                              avs_writedata[7:4]} : burst_ff);
        `CBLF_IDX_INTMASK:  if (avs_byteenable[0]) intMask_ff <= avs_writedata[2:0];
        `CBLF_IDX_CTRL:     if (avs_byteenable[0]) frmEn_ff <= avs_writedata[0];
        default:            ;
      endcase
    end
  end

  // host read pointer; a write counts as a completed read transfer
  logic rdPtrWr;
  assign rdPtrWr = wrAcc && (regIdx == `CBLF_IDX_RDPTR);

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      rdPtr_ff <= `CBLF_RST_PTR;
    end else if (rdPtrWr) begin
      rdPtr_ff <= 25'(mergeBe({3'h0, rdPtr_ff, 4'h0}, avs_writedata, avs_byteenable) >> 4);
    end
  end

  // millisecond prescaler shared by all latency timers
  logic [31:0] msCnt_ff;
  logic        msTick;
  assign msTick = (msCnt_ff == 32'(MS_CYCLES - 1));

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      msCnt_ff <= 32'h00000000;
    end else begin
      msCnt_ff <= msTick ? 32'h00000000 : msCnt_ff + 32'h00000001;
    end
  end

  // test generator: fractional accumulator gives mul words per div cycles
  logic [7:0]  genMul;
  logic [23:0] genDiv;
  logic        genOn;
  logic [24:0] genAcc_ff;
  logic [24:0] genSum;
  logic        genFire;
  logic        genSat;
  assign genMul  = genRate_ff[`CBLF_GEN_MUL_MSB:`CBLF_GEN_MUL_LSB];
  assign genDiv  = genRate_ff[`CBLF_GEN_DIV_MSB:0];
  assign genOn   = (genMul != 8'h00) && (genDiv != 24'h000000);
  assign genSat  = {16'h0000, genMul} >= genDiv;
  assign genSum  = genAcc_ff + {17'h00000, genMul};
  assign genFire = genOn && (genSat || (genSum >= {1'b0, genDiv}));

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      genAcc_ff <= 25'h0000000;
    end else if (!genOn || genSat) begin
      genAcc_ff <= 25'h0000000; // saturated rate needs no remainder
    end else begin
      genAcc_ff <= genFire ? genSum - {1'b0, genDiv} : genSum;
    end
  end

  // source select and word strobe presented to the channel
  logic inBeat;
  assign inBeat = genOn ? genFire : srcBeat;

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      genSelect <= 1'b0;
      genBeat   <= 1'b0;
    end else begin
      genSelect <= genOn;
      genBeat   <= genFire;
    end
  end

  // latency timers, all on the one shared limit
  logic wrExpired;
  logic rdExpired;
  logic frExpired;
  logic frSendNow;
  logic unread;
  logic collectFire;
  assign unread      = (wrPtr_ff != rdPtr_ff);
  assign collectFire = rdExpired && unread;

  cblf_latency_timer uWrTimer (
    .clk_sys (clk_sys),
    .reset   (reset),
    .msTick  (msTick),
    .restart (memWrDone),
    .limit   (latency_ff),
    .expired (wrExpired)
  );

  cblf_latency_timer uRdTimer (
    .clk_sys (clk_sys),
    .reset   (reset),
    .msTick  (msTick),
    .restart (rdPtrWr || collectFire),
    .limit   (latency_ff),
    .expired (rdExpired)
  );

  cblf_latency_timer uFrTimer (
    .clk_sys (clk_sys),
    .reset   (reset),
    .msTick  (msTick),
    .restart (frSendNow),
    .limit   (latency_ff),
    .expired (frExpired)
  );

  // write scheduler
  cblf_pkg::cblf_wstate_e wState_ff;
  logic [9:0]  fifoCnt_ff;
  logic [9:0]  pageRem;
  logic        fullBurst;
  logic        timedFlush;
  logic        issue;
  logic        usePref;
  logic [9:0]  issueLen;
  logic        ovfEvent;
  logic        ovwEvent;
  logic [25:0] usedAfter;

  assign pageRem    = {1'b0, `CBLF_PAGE_BEATS} - {2'h0, wrPtr_ff[7:0]};
  assign fullBurst  = (burst_ff != 8'h00) && (fifoCnt_ff >= {2'h0, burst_ff});
  assign timedFlush = wrExpired && (fifoCnt_ff != 10'h000);
  assign issue      = (wState_ff == cblf_pkg::CBLF_W_IDLE) &&
                      (fullBurst || timedFlush || intStat_ff[`CBLF_INT_OVERFLOW]) &&
                      (fifoCnt_ff != 10'h000);
  // preferred length only inside the page, no overflow, latency not elapsed
  assign usePref    = fullBurst && ({2'h0, burst_ff} <= pageRem) &&
                      !intStat_ff[`CBLF_INT_OVERFLOW] && !wrExpired;
  assign issueLen   = usePref ? {2'h0, burst_ff} : minBeats(fifoCnt_ff, pageRem);
  assign ovfEvent   = inBeat && (fifoCnt_ff == `CBLF_FIFO_DEPTH) && !issue;
  // unread span after this write; above pointer space means unread data is lost
  assign usedAfter  = {1'b0, wrPtr_ff - rdPtr_ff} + {17'h00000, memWrBeats};
  assign ovwEvent   = memWrDone && (wState_ff == cblf_pkg::CBLF_W_BUSY) &&
                      usedAfter[25];

  // beats waiting to be written; saturates at depth and flags overflow
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      fifoCnt_ff <= 10'h000;
    end else begin
      fifoCnt_ff <= fifoCnt_ff - (issue ? issueLen : 10'h000)
                    + ((inBeat && !ovfEvent) ? 10'h001 : 10'h000);
    end
  end

  // command handshake: one command outstanding until memory reports done
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      wState_ff  <= cblf_pkg::CBLF_W_IDLE;
      memWrReq   <= 1'b0;
      memWrAddr  <= 29'h00000000;
      memWrBeats <= 9'h000;
    end else begin
      memWrReq <= 1'b0;
      case (wState_ff)
        cblf_pkg::CBLF_W_IDLE: begin
          if (issue) begin
            wState_ff  <= cblf_pkg::CBLF_W_BUSY;
            memWrReq   <= 1'b1;
            memWrAddr  <= {wrPtr_ff, 4'h0};
            memWrBeats <= issueLen[8:0];
          end
        end
        cblf_pkg::CBLF_W_BUSY: begin
          if (memWrDone) begin
            wState_ff <= cblf_pkg::CBLF_W_IDLE;
          end
        end
        default: wState_ff <= cblf_pkg::CBLF_W_IDLE;
      endcase
    end
  end

  // write pointer advances when the memory finishes a transfer
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      wrPtr_ff <= `CBLF_RST_PTR;
    end else if (memWrDone && (wState_ff == cblf_pkg::CBLF_W_BUSY)) begin
      wrPtr_ff <= wrPtr_ff + {16'h0000, memWrBeats};
    end
  end

  // overwrite pointer holds the read pointer at which unread data was lost
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      ovwPtr_ff <= `CBLF_RST_PTR;
    end else if (ovwEvent) begin
      ovwPtr_ff <= rdPtr_ff;
    end
  end

  // sticky status: hardware set wins over a write-one clear in the same cycle
  logic [`CBLF_INT_WIDTH-1:0] intSet;
  logic [`CBLF_INT_WIDTH-1:0] intClr;
  assign intSet = {ovfEvent, ovwEvent, collectFire};
  assign intClr = (wrAcc && (regIdx == `CBLF_IDX_INTSTAT) && avs_byteenable[0]) ?
                  avs_writedata[`CBLF_INT_WIDTH-1:0] : '0;

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      intStat_ff <= '0;
    end else begin
      intStat_ff <= (intStat_ff & ~intClr) | intSet;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |(intStat_ff & intMask_ff);
    end
  end

  // framer: samples accumulate while enabled, whole backlog goes in each frame
  logic [16:0] frCnt_ff;
  logic        frNominal;
  logic        frShort;
  assign frNominal = (frameTgt_ff != 16'h0000) && (frCnt_ff >= {1'b0, frameTgt_ff});
  assign frShort   = frExpired || !frmEn_ff;
  // a stalled frameReady lets frCnt grow past the target
  assign frSendNow = frameReady && (frCnt_ff != 17'h00000) && (frNominal || frShort);

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      frCnt_ff <= 17'h00000;
    end else begin
      if (frSendNow) begin
        frCnt_ff <= {16'h0000, frmEn_ff && srcSample};
      end else if (frmEn_ff && srcSample && (frCnt_ff != 17'h1FFFF)) begin
        frCnt_ff <= frCnt_ff + 17'h00001;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      frameSend <= 1'b0;
      frameLen  <= 17'h00000;
    end else begin
      frameSend <= frSendNow;
      if (frSendNow) begin
        frameLen <= frCnt_ff;
      end
    end
  end

  // bus outputs straight from flops
  assign avs_readdata    = readData_ff;
  assign avs_waitrequest = waitReq_ff;
  assign irq             = irq_ff;

endmodule

// [src/cblf_map.svh]
// register indices, field positions, reset values and timing constants
`ifndef CBLF_MAP_SVH
`define CBLF_MAP_SVH

// register indices; byte address is four times the index
`define CBLF_IDX_BURST      4'h2
`define CBLF_IDX_LATENCY    4'h4
`define CBLF_IDX_RDPTR      4'h5
`define CBLF_IDX_WRPTR      4'h6
`define CBLF_IDX_OVWPTR     4'h7
`define CBLF_IDX_GENRATE    4'h8
`define CBLF_IDX_FRAMETGT   4'h9
`define CBLF_IDX_INTSTAT    4'hA
`define CBLF_IDX_INTMASK    4'hB
`define CBLF_IDX_CTRL       4'hC

// field positions
`define CBLF_PTR_MSB        28
`define CBLF_PTR_LSB        4
`define CBLF_BURST_MSB      11
`define CBLF_BURST_LSB      4
`define CBLF_LAT_MSB        15
`define CBLF_GEN_MUL_MSB    31
`define CBLF_GEN_MUL_LSB    24
`define CBLF_GEN_DIV_MSB    23
`define CBLF_TGT_MSB        15
`define CBLF_CTRL_FRM_EN    0

// interrupt status and mask bits
`define CBLF_INT_COLLECTED  0
`define CBLF_INT_OVERWRITE  1
`define CBLF_INT_OVERFLOW   2
`define CBLF_INT_WIDTH      3

// reset values
`define CBLF_RST_LATENCY    16'h0000
`define CBLF_RST_PTR        25'h0000000
`define CBLF_RST_GENRATE    32'h00000000
`define CBLF_RST_FRAMETGT   16'h0000
`define CBLF_RST_BURST      8'h00

// sizes: memory page in beats, staging fifo depth in beats
`define CBLF_PAGE_BEATS     9'h100
`define CBLF_FIFO_DEPTH     10'h200

// millisecond timebase
`define CBLF_MS_NS          1000000
`define CBLF_CLK_NS         20

`endif

// [src/cblf_pkg.sv]
// types shared by the latency framer design
package cblf_pkg;

  // write scheduler states
  typedef enum logic [1:0] {
    CBLF_W_IDLE = 2'b00,
    CBLF_W_BUSY = 2'b01
  } cblf_wstate_e;

  // 128-bit word pointer into the buffer
  typedef logic [24:0] cblf_ptr_t;

endpackage

// [src/cblf_latency_timer.sv]
// millisecond latency timer with restart and shared limit
`include "cblf_map.svh"

module cblf_latency_timer (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        reset,
  // control
  input  wire logic        msTick,
  input  wire logic        restart,
  input  wire logic [15:0] limit,
  // status
  output logic             expired
);

  logic [15:0] count_ff;

  // counts ms since last restart, saturates so it never wraps back below limit
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      count_ff <= 16'h0000;
    end else if (restart) begin
      count_ff <= 16'h0000;
    end else if (msTick && (count_ff != 16'hFFFF)) begin
      count_ff <= count_ff + 16'h0001;
    end
  end

  // zero limit disables time-driven scheduling altogether; restart is left out here
  // because callers build restart from expired, which would close a combinational loop
  assign expired = (limit != 16'h0000) && (count_ff >= limit);

endmodule

// [verification/cblf_top_monitor.sv]
// checker watching the top ports of the latency framer
`include "cblf_map.svh"

module cblf_top_monitor (
  // clock and reset
  input wire logic        clk_sys,
  input wire logic        reset,
  // register bus
  input wire logic [5:0]  avs_address,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic        avs_waitrequest,
  // memory, generator, framer, interrupt
  input wire logic        memWrReq,
  input wire logic [28:0] memWrAddr,
  input wire logic [8:0]  memWrBeats,
  input wire logic        memWrDone,
  input wire logic        genSelect,
  input wire logic        genBeat,
  input wire logic        frameSend,
  input wire logic [16:0] frameLen,
  input wire logic        frameReady,
  input wire logic        irq
);
  logic        busy_ff;
  logic [28:0] expAddr_ff;
  logic [7:0]  genMul_ff;
  logic [23:0] genDiv_ff;
  logic        genOff;
  logic        genSat;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  // one command in flight; the next address continues the last one
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      busy_ff    <= 1'b0;
      expAddr_ff <= 29'h00000000;
    end else if (memWrReq) begin
      busy_ff    <= 1'b1;
      expAddr_ff <= memWrAddr + {16'h0000, memWrBeats, 4'h0};
    end else if (memWrDone) begin
      busy_ff <= 1'b0;
    end
  end
  // shadow of the rate word; assumes full-word writes
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      {genMul_ff, genDiv_ff} <= 32'h00000000;
    end else if (avs_write && !avs_waitrequest && avs_address[5:2] == `CBLF_IDX_GENRATE) begin
      {genMul_ff, genDiv_ff} <= avs_writedata;
    end
  end
  assign genOff = (genMul_ff == 8'h00) || (genDiv_ff == 24'h000000);
  assign genSat = !genOff && ({16'h0000, genMul_ff} >= genDiv_ff);
  a_cmd_single: assert property (memWrReq |-> !busy_ff)
    else $error("second memory command before completion");
  a_cmd_addr: assert property (memWrReq |-> memWrAddr == expAddr_ff && memWrAddr[3:0] == 4'h0)
    else $error("memory command address does not follow previous transfer");
  a_cmd_page: assert property (memWrReq |-> memWrBeats != 9'h000
      && ({2'b00, memWrAddr[11:4]} + {1'b0, memWrBeats}) <= 10'h100)
    else $error("memory command crosses a page or is empty");
  a_addr_hold: assert property (!memWrReq |-> $stable(memWrAddr) && $stable(memWrBeats))
    else $error("command fields moved without a command");
  a_frame_ready: assert property (frameSend |-> $past(frameReady))
    else $error("frame sent while downstream not ready");
  a_frame_len: assert property (frameSend |-> frameLen != 17'h00000)
    else $error("empty frame sent");
  a_len_hold: assert property (!frameSend |-> $stable(frameLen))
    else $error("frame length moved without a frame");
  a_gen_off: assert property (genOff && $past(genOff) && $past(genOff, 2) |-> !genSelect && !genBeat)
    else $error("generator active with zero rate field");
  a_gen_full: assert property (genSat [*4] |-> genSelect && genBeat)
    else $error("saturated generator missed a cycle");
  c_cmd_done: cover property (memWrReq ##[1:20] memWrDone);
  c_gen_run: cover property (genBeat [*3]);
  c_frame: cover property (frameSend);
  c_irq: cover property (irq);
endmodule

// [verification/cblf_mem_model.sv]
// memory side model: completes each write command after a set lag
module cblf_mem_model (
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       reset,
  // command in, completion out
  input  wire logic       memWrReq,
  input  wire logic [3:0] lag,
  output logic            memWrDone
);
  logic [4:0] waitCnt_ff;
  // countdown per command; lag 0 answers promptly, larger lags stall
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      waitCnt_ff <= 5'h00;
      memWrDone  <= 1'b0;
    end else begin
      memWrDone <= (waitCnt_ff == 5'h01);
      if (memWrReq) waitCnt_ff <= {1'b0, lag} + 5'h01;
      else if (waitCnt_ff != 5'h00) waitCnt_ff <= waitCnt_ff - 5'h01;
    end
  end
endmodule

// [verification/test_circular_buffer_latency_framer.sv]
// self-checking bench for the circular buffer latency framer
module test_circular_buffer_latency_framer;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [3:0] idx; logic [31:0] wd; logic [31:0] ex;} cblf_row_s;
  logic        clk_sys, reset, avs_read, avs_write, avs_waitrequest, srcBeat, srcSample;
  logic        memWrReq, memWrDone, genSelect, genBeat, frameSend, frameReady, irq;
  logic [5:0]  avs_address;
  logic [3:0]  avs_byteenable, lag;
  logic [31:0] avs_writedata, avs_readdata, rdData;
  logic [28:0] memWrAddr;
  logic [8:0]  memWrBeats;
  logic [16:0] frameLen;
  int          err_count = 0;
  int          check_count = 0;
  int          evCnt [3] = '{0, 0, 0};
  int          n;
  cblf_row_s   rows [7] = '{'{4'h4, 32'hFFFF1234, 32'h00001234}, '{4'h5, 32'hFFFFFFFF, 32'h1FFFFFF0},
    '{4'h6, 32'h12345670, 32'h00000000}, '{4'h7, 32'h0000ABC0, 32'h00000000},
    '{4'h8, 32'h05000000, 32'h05000000}, '{4'h9, 32'hABCD0004, 32'h00000004},
    '{4'hF, 32'hFFFFFFFF, 32'h00000000}};
  // short millisecond keeps latency runs brief
  cblf_top #(.MS_CYCLES(10)) DUT (.clk_sys(clk_sys), .reset(reset), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .srcBeat(srcBeat), .srcSample(srcSample),
    .memWrReq(memWrReq), .memWrAddr(memWrAddr), .memWrBeats(memWrBeats), .memWrDone(memWrDone),
    .genSelect(genSelect), .genBeat(genBeat), .frameSend(frameSend), .frameLen(frameLen),
    .frameReady(frameReady), .irq(irq));
  cblf_mem_model mem (.clk_sys(clk_sys), .reset(reset), .memWrReq(memWrReq), .lag(lag),
    .memWrDone(memWrDone));
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  // tally commands, completions and frames; non-blocking so readers see settled counts
  always @(posedge clk_sys) begin
    if (memWrReq === 1'b1) evCnt[0] <= evCnt[0] + 1;
    if (memWrDone === 1'b1) evCnt[1] <= evCnt[1] + 1;
    if (frameSend === 1'b1) evCnt[2] <= evCnt[2] + 1;
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one bus access, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [3:0] idx, input logic [31:0] wd);
    int k;
    k = 0;
    avs_address <= {idx, 2'b00};
    avs_writedata <= wd;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge clk_sys);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 50);
    rdData = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk_sys);
    if (k >= 50) chk("bus answer", 32'h0, 32'h1);
  endtask
  task automatic rdc(input logic [3:0] idx, input logic [31:0] e);
    bus(1'b0, idx, 32'h00000000);
    chk("register read", e, rdData);
  endtask
  task automatic waitEv(input int k, input int target);
    int t;
    t = 0;
    while (evCnt[k] < target && t < 300) begin
      @(posedge clk_sys);
      t++;
    end
    chk("event count", 32'(target), 32'(evCnt[k]));
  endtask
  task automatic pulse(input logic smp, input int cnt);
    repeat (cnt) begin
      srcBeat <= !smp;
      srcSample <= smp;
      @(posedge clk_sys);
      srcBeat <= 1'b0;
      srcSample <= 1'b0;
      @(posedge clk_sys);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // watchdog: the whole sequence needs a few hundred cycles
  initial begin
    repeat (20000) @(posedge clk_sys);
    err_count++;
    end_sim;
  end
  initial begin
    {reset, avs_read, avs_write, srcBeat, srcSample, frameReady} <= 6'h20;
    {avs_address, avs_writedata, avs_byteenable, lag} <= {6'h00, 32'h0, 4'hF, 4'h0};
    repeat (3) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    // field widths, read-only places and an unmapped index
    foreach (rows[i]) begin
      bus(1'b1, rows[i].idx, rows[i].wd);
      rdc(rows[i].idx, rows[i].ex);
    end
    // reset in mid-run brings registers 4 to 9 back to zero
    reset <= 1'b1;
    repeat (3) @(posedge clk_sys);
    chk("waitrequest in reset", 32'h1, {31'h0, avs_waitrequest});
    reset <= 1'b0;
    @(posedge clk_sys);
    for (int r = 4; r < 10; r++) rdc(r[3:0], 32'h0);
    // zero limit: a lone beat waits, a full burst of four goes out to a slow memory
    lag <= 4'h5;
    bus(1'b1, 4'h2, 32'h00000040);
    pulse(1'b0, 1);
    repeat (60) @(posedge clk_sys);
    chk("no timed command", 32'h0, 32'(evCnt[0]));
    pulse(1'b0, 3);
    waitEv(0, 1);
    chk("burst beats", 32'h4, {23'h0, memWrBeats});
    chk("burst address", 32'h0, {3'h0, memWrAddr});
    waitEv(1, 1);
    rdc(4'h6, 32'h00000040);
    // one millisecond limit flushes a single beat to a prompt memory
    lag <= 4'h0;
    bus(1'b1, 4'h4, 32'h00000001);
    pulse(1'b0, 1);
    waitEv(0, 2);
    chk("flush beats", 32'h1, {23'h0, memWrBeats});
    chk("flush address", 32'h40, {3'h0, memWrAddr});
    waitEv(1, 2);
    // unread data raises collected; mask hides it; catching up and write-one clear it
    bus(1'b1, 4'hB, 32'h00000007);
    rdc(4'hA, 32'h00000001);
    chk("irq raised", 32'h1, {31'h0, irq});
    bus(1'b1, 4'hB, 32'h00000000);
    @(posedge clk_sys);
    chk("irq masked", 32'h0, {31'h0, irq});
    bus(1'b1, 4'h5, 32'h00000050);
    bus(1'b1, 4'hA, 32'h00000001);
    bus(1'b1, 4'hB, 32'h00000007);
    rdc(4'hA, 32'h0);
    chk("irq cleared", 32'h0, {31'h0, irq});
    // framer: stall grows the frame, zero limit waits, disable and latency flush
    bus(1'b1, 4'h4, 32'h0);
    bus(1'b1, 4'h9, 32'h00000003);
    bus(1'b1, 4'hC, 32'h00000001);
    pulse(1'b1, 5);
    chk("no frame while stalled", 32'h0, 32'(evCnt[2]));
    frameReady <= 1'b1;
    waitEv(2, 1);
    chk("oversize frame", 32'h5, {15'h0, frameLen});
    pulse(1'b1, 2);
    repeat (40) @(posedge clk_sys);
    chk("no short frame", 32'h1, 32'(evCnt[2]));
    bus(1'b1, 4'hC, 32'h0);
    waitEv(2, 2);
    chk("frame on disable", 32'h2, {15'h0, frameLen});
    bus(1'b1, 4'h4, 32'h1);
    bus(1'b1, 4'hC, 32'h1);
    pulse(1'b1, 1);
    waitEv(2, 3);
    chk("frame on latency", 32'h1, {15'h0, frameLen});
    // generator saturated, then one word in three, then off
    bus(1'b1, 4'h8, 32'h03000002);
    repeat (4) @(posedge clk_sys);
    repeat (4) begin
      @(posedge clk_sys);
      chk("saturated gen", 32'h3, {30'h0, genSelect, genBeat});
    end
    bus(1'b1, 4'h8, 32'h01000003);
    repeat (4) @(posedge clk_sys);
    n = 0;
    repeat (30) begin
      @(posedge clk_sys);
      n = n + int'(genBeat === 1'b1);
    end
    chk("gen words", 32'd10, 32'(n));
    bus(1'b1, 4'h8, 32'h00000005);
    repeat (4) @(posedge clk_sys);
    chk("gen off", 32'h0, {30'h0, genSelect, genBeat});
    end_sim;
  end
endmodule

bind cblf_top cblf_top_monitor u_mon (.clk_sys(clk_sys), .reset(reset),
  .avs_address(avs_address), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_waitrequest(avs_waitrequest), .memWrReq(memWrReq), .memWrAddr(memWrAddr),
  .memWrBeats(memWrBeats), .memWrDone(memWrDone), .genSelect(genSelect), .genBeat(genBeat),
  .frameSend(frameSend), .frameLen(frameLen), .frameReady(frameReady), .irq(irq));
